//--- verilog/qd_pkg.sv
// Constants, register map and carrier types of the three-axis quadrature decoder
// Summary of operation
// R1 - X direction flag read-only in bit 0; one means up, zero down.
// R2 - Y direction flag read-only in bit 0 of its register, same encoding.
// R3 - Z direction flag read-only in bit 0 of a third register.
// R4 - X movement count is 8 bits, read-only, reset to zero.
// R5 - Y movement count is 8 bits, read-only, reset to zero.
// R6 - Z movement count is 8 bits, read-only, reset to zero.
// R7 - Decoding runs only while control bit 2 (enable) is one.
// R8 - Writing one to control bit 1 clears all flags and counts.
// R9 - Mode one: count keeps rising until the direction of movement changes.
// R10 - Mode zero: count falls on reversed steps; mode resets to zero.
// R11 - Phase A changing before phase B means downward movement.
// R12 - Phase B changing before phase A means upward movement.
// R13 - One count step per phase edge, a quarter quadrature period.
// R14 - Y and Z pairs decode exactly like X, each independently.
// R15 - All six phase inputs pass two flip-flops before edge detection.
// R16 - Counts wrap modulo 256 on overflow and underflow.
package qd_pkg;

   // Register indexes; the byte address is four times the index
   localparam logic [15:0] QD_IDX_X_DIRECTION     = 16'h2560;
   localparam logic [15:0] QD_IDX_X_COUNT         = 16'h2561;
   localparam logic [15:0] QD_IDX_Y_DIRECTION     = 16'h2562;
   localparam logic [15:0] QD_IDX_Y_COUNT         = 16'h2563;
   localparam logic [15:0] QD_IDX_Z_DIRECTION     = 16'h2564;
   localparam logic [15:0] QD_IDX_Z_COUNT         = 16'h2565;
   localparam logic [15:0] QD_IDX_DECODER_CONTROL = 16'h2566;

   // Control field positions
   localparam int QD_CTRL_MODE_BIT   = 0;
   localparam int QD_CTRL_INIT_BIT   = 1;
   localparam int QD_CTRL_ENABLE_BIT = 2;

   // Field position of the direction flag
   localparam int QD_DIR_FLAG_BIT = 0;

   // Reset values
   localparam logic [7:0] QD_COUNT_RESET = 8'h00;
   localparam logic       QD_DIR_RESET   = 1'b0;
   localparam logic       QD_MODE_RESET  = 1'b0;
   localparam logic       QD_ENA_RESET   = 1'b0;

   // Direction encoding
   localparam logic QD_DIR_UP   = 1'b1;
   localparam logic QD_DIR_DOWN = 1'b0;

   // Counter behaviour on reversal
   typedef enum logic [0:0] {
      QD_MODE_NET     = 1'b0,
      QD_MODE_RESTART = 1'b1
   } qd_mode_t;

   // Software control state
   typedef struct packed {
      logic     enable;
      qd_mode_t mode;
   } qd_ctrl_t;

   // State of one axis
   typedef struct packed {
      logic       dir_flag;
      logic [7:0] move_count;
   } qd_axis_t;

   // Decoded step of one axis
   typedef struct packed {
      logic step;
      logic up;
   } qd_step_t;

endpackage : qd_pkg

//--- verilog/qd_axis.sv
// One axis: phase synchroniser and quarter-period step decoder
module qd_axis
   import qd_pkg::*;
(
   // Clock and reset
   input  wire logic     i_clk,
   input  wire logic     i_sys_rst,
   // Phase pins from the encoder
   input  wire logic     i_phase_a,
   input  wire logic     i_phase_b,
   // Decoder control
   input  wire logic     i_enable,
   // Decoded step
   output qd_step_t      o_step
);

   logic [1:0] sync_meta;
   logic [1:0] sync_q;
   logic [1:0] prev_q;
   logic [1:0] next_prev;
   qd_step_t   next_step;
   qd_step_t   step_q;

   // Two-stage synchroniser; only sync_q reads sync_meta
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sync_meta <= 2'h0;
         sync_q    <= 2'h0;
      end else begin
         sync_meta <= {i_phase_a, i_phase_b};  // [R15]
         sync_q    <= sync_meta;                // [R15]
      end
   end

   // Gray-step decode; prev tracks even while disabled so enabling adds no false step
   always_comb begin
      next_prev      = sync_q;
      next_step.step = 1'b0;
      next_step.up   = QD_DIR_DOWN;
      if (i_enable) begin  // [R7]
         case ({prev_q, sync_q})
            // A leads B: 00-10-11-01-00
            4'b00_10, 4'b10_11, 4'b11_01, 4'b01_00: begin
               next_step.step = 1'b1;       // [R13]
               next_step.up   = QD_DIR_DOWN; // [R11]
            end
            // B leads A: 00-01-11-10-00
            4'b00_01, 4'b01_11, 4'b11_10, 4'b10_00: begin
               next_step.step = 1'b1;     // [R13]
               next_step.up   = QD_DIR_UP; // [R12]
            end
            // No change, or both phases jumped: ambiguous, ignored
            default: begin
               next_step.step = 1'b0;
            end
         endcase
      end
   end

   // Register decode state
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         prev_q <= 2'h0;
         step_q <= '0;
      end else begin
         prev_q <= next_prev;
         step_q <= next_step;
      end
   end

   assign o_step = step_q;

endmodule : qd_axis

//--- verilog/qd_top.sv
// Three-axis quadrature decoder with APB register access
module qd_top
   import qd_pkg::*;
#(
   parameter int AXES = 3
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [31:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   input  wire logic [3:0]  i_pstrb,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // Phase pins, X Y Z
   input  wire logic        i_x_phase_a,
   input  wire logic        i_x_phase_b,
   input  wire logic        i_y_phase_a,
   input  wire logic        i_y_phase_b,
   input  wire logic        i_z_phase_a,
   input  wire logic        i_z_phase_b
);

   qd_ctrl_t        ctrl;
   qd_ctrl_t        next_ctrl;
   logic            decoder_init;
   qd_step_t        step     [AXES];
   qd_axis_t        axis     [AXES];
   qd_axis_t        next_axis[AXES];
   logic            moved    [AXES];
   logic            next_moved[AXES];
   logic [AXES-1:0] phase_a;
   logic [AXES-1:0] phase_b;
   logic [31:0]     next_prdata;
   logic [31:0]     prdata_q;
   logic            next_slverr;
   logic [15:0]     reg_idx;
   logic            addr_ok;
   logic            access;
   logic            wr_access;

   assign phase_a = {i_z_phase_a, i_y_phase_a, i_x_phase_a};
   assign phase_b = {i_z_phase_b, i_y_phase_b, i_x_phase_b};

   // Per-axis decoders, identical for each pair
   for (genvar g = 0; g < AXES; g++) begin : g_axis
      qd_axis u_axis (  // [R14]
         .i_clk     (i_clk),
         .i_sys_rst (i_sys_rst),
         .i_phase_a (phase_a[g]),
         .i_phase_b (phase_b[g]),
         .i_enable  (ctrl.enable),
         .o_step    (step[g])
      );
   end

   // APB decode; registers sit on aligned words, low two address bits must be zero
   assign reg_idx   = i_paddr[17:2];
   assign addr_ok   = (i_paddr[31:18] == 14'h0000) && (i_paddr[1:0] == 2'b00);
   assign access    = i_psel && i_penable;
   assign wr_access = access && i_pwrite && addr_ok
                      && (reg_idx == QD_IDX_DECODER_CONTROL) && i_pstrb[0];

   // Initialise is a one-cycle pulse from the write; the bit itself is not stored
   assign decoder_init = wr_access && i_pwdata[QD_CTRL_INIT_BIT];  // [R8]

   // Control register next value
   always_comb begin
      next_ctrl = ctrl;
      if (wr_access) begin
         next_ctrl.enable = i_pwdata[QD_CTRL_ENABLE_BIT];             // [R7]
         next_ctrl.mode   = qd_mode_t'(i_pwdata[QD_CTRL_MODE_BIT]);  // [R9] [R10]
      end
   end

   // Control register
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl.enable <= QD_ENA_RESET;
         ctrl.mode   <= qd_mode_t'(QD_MODE_RESET);  // [R10]
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // Axis counters; init wins over a step arriving in the same cycle
   always_comb begin
      for (int i = 0; i < AXES; i++) begin
         next_axis[i]  = axis[i];
         next_moved[i] = moved[i];
         if (decoder_init) begin
            next_axis[i].dir_flag   = QD_DIR_RESET;    // [R8]
            next_axis[i].move_count = QD_COUNT_RESET;  // [R8]
            next_moved[i]           = 1'b0;
         end else if (step[i].step) begin
            next_axis[i].dir_flag = step[i].up;  // [R1] [R2] [R3]
            next_moved[i]         = 1'b1;
            if (ctrl.mode == QD_MODE_RESTART) begin
               // Rise while direction holds, restart on reversal
               if (moved[i] && (step[i].up != axis[i].dir_flag)) begin
                  next_axis[i].move_count = 8'h01;  // [R9]
               end else begin
                  next_axis[i].move_count = axis[i].move_count + 8'h01;  // [R9] [R16]
               end
            end else begin
               // Net position: up adds, down takes away, so reversals count back
               if (step[i].up == QD_DIR_UP) begin
                  next_axis[i].move_count = axis[i].move_count + 8'h01;  // [R16]
               end else begin
                  next_axis[i].move_count = axis[i].move_count - 8'h01;  // [R10] [R16]
               end
            end
         end
      end
   end

   // Axis state registers
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         for (int i = 0; i < AXES; i++) begin
            axis[i].dir_flag   <= QD_DIR_RESET;    // [R1] [R2] [R3]
            axis[i].move_count <= QD_COUNT_RESET;  // [R4] [R5] [R6]
            moved[i]           <= 1'b0;
         end
      end else begin
         for (int i = 0; i < AXES; i++) begin
            axis[i]  <= next_axis[i];
            moved[i] <= next_moved[i];
         end
      end
   end

   // Read mux; flag sits in bit 0, reserved bits read zero
   always_comb begin
      next_prdata = 32'h0000_0000;
      next_slverr = 1'b0;
      if (!addr_ok) begin
         next_slverr = 1'b1;
      end else if (reg_idx == QD_IDX_X_DIRECTION) begin
         next_prdata[QD_DIR_FLAG_BIT] = axis[0].dir_flag;  // [R1]
      end else if (reg_idx == QD_IDX_X_COUNT) begin
         next_prdata[7:0] = axis[0].move_count;  // [R4]
      end else if (reg_idx == QD_IDX_Y_DIRECTION) begin
         next_prdata[QD_DIR_FLAG_BIT] = axis[1].dir_flag;  // [R2]
      end else if (reg_idx == QD_IDX_Y_COUNT) begin
         next_prdata[7:0] = axis[1].move_count;  // [R5]
      end else if (reg_idx == QD_IDX_Z_DIRECTION) begin
         next_prdata[QD_DIR_FLAG_BIT] = axis[2].dir_flag;  // [R3]
      end else if (reg_idx == QD_IDX_Z_COUNT) begin
         next_prdata[7:0] = axis[2].move_count;  // [R6]
      end else if (reg_idx == QD_IDX_DECODER_CONTROL) begin
         next_prdata[QD_CTRL_ENABLE_BIT] = ctrl.enable;
         next_prdata[QD_CTRL_MODE_BIT]   = ctrl.mode;
      end else begin
         next_slverr = 1'b1;
      end
      // Writes to read-only registers are refused
      if (i_pwrite && addr_ok && (reg_idx != QD_IDX_DECODER_CONTROL)) begin
         next_slverr = 1'b1;
      end
   end

   // Read data is captured in setup so it comes from a flip-flop in the access phase
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         prdata_q <= 32'h0000_0000;
      end else if (i_psel && !i_penable) begin
         prdata_q <= i_pwrite ? 32'h0000_0000 : next_prdata;
      end else begin
         prdata_q <= prdata_q;
      end
   end

   // Zero-wait slave: the access phase always completes in one cycle
   assign o_pready  = 1'b1;
   assign o_pslverr = access && next_slverr;
   assign o_prdata  = prdata_q;

endmodule : qd_top

//--- tb/qd_top_sva.sv
// Port-level assertions for the quadrature decoder top
module qd_top_sva
   import qd_pkg::*;
(
   // Clock and reset
   input wire logic        i_clk,
   input wire logic        i_sys_rst,
   // APB slave side
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [31:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0]  i_pstrb,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr
);
   timeunit 1ns;
   timeprecision 1ns;
   // Access-phase read and write strobes
   wire acc = i_psel && i_penable;
   wire rd  = acc && !i_pwrite;
   wire ctl = i_paddr == 32'h0000_9598;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   a_xdir_reserved: assert property (rd && i_paddr == 32'h0000_9580 |-> o_prdata[31:1] == 0)
      else $error("x direction upper bits set");
   a_ydir_reserved: assert property (rd && i_paddr == 32'h0000_9588 |-> o_prdata[31:1] == 0)
      else $error("y direction upper bits set");
   a_zdir_reserved: assert property (rd && i_paddr == 32'h0000_9590 |-> o_prdata[31:1] == 0)
      else $error("z direction upper bits set");
   a_xcnt_width: assert property (rd && i_paddr == 32'h0000_9584 |-> o_prdata[31:8] == 0)
      else $error("x count wider than a byte");
   a_ycnt_width: assert property (rd && i_paddr == 32'h0000_958c |-> o_prdata[31:8] == 0)
      else $error("y count wider than a byte");
   a_zcnt_width: assert property (rd && i_paddr == 32'h0000_9594 |-> o_prdata[31:8] == 0)
      else $error("z count wider than a byte");
   a_ro_write_err: assert property (acc && i_pwrite && i_paddr[1:0] == 2'h0
      && i_paddr >= 32'h0000_9580 && i_paddr <= 32'h0000_9594 |-> o_pslverr)
      else $error("write to read-only register accepted");
   a_init_reads_zero: assert property (rd && ctl |-> !o_prdata[1] && o_prdata[31:3] == 0)
      else $error("control readback shows init or reserved bits");
   // Control written, one idle cycle, then read back
   a_ctrl_readback: assert property (acc && i_pwrite && ctl && i_pstrb[0] ##1 !i_psel
      ##1 i_psel && !i_penable ##1 rd && ctl
      |-> o_prdata[2:0] == {$past(i_pwdata[2], 3), 1'b0, $past(i_pwdata[0], 3)})
      else $error("control readback differs from write");
endmodule : qd_top_sva

bind qd_top qd_top_sva u_sva (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
   .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr));

//--- tb/qd_enc_model.sv
// Behavioural quadrature encoder of one pointing-device axis
module qd_enc_model (
   // Clock and step request
   input  wire logic i_clk,
   input  wire logic i_req,
   input  wire logic i_up,
   // Phase outputs
   output logic      o_a,
   output logic      o_b
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] pos = 2'h0;
   // Gray position: B leads moving up, A leads moving down, one edge per request
   always @(posedge i_clk) begin
      if (i_req) pos <= i_up ? pos + 2'h1 : pos - 2'h1;
   end
   assign o_a = pos[1];
   assign o_b = pos[1] ^ pos[0];
endmodule : qd_enc_model

//--- tb/qd_top_tb.sv
// Self-checking bench for the three-axis quadrature decoder
module qd_top_tb
   import qd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  strb = 4'hf;
   logic [2:0]  req = 3'h0;
   logic [2:0]  up = 3'h0;
   logic [31:0] prdata, rd, seed = 32'h0000_b87e;
   wire  [2:0]  pa, pb;  // Each bit driven by one encoder instance
   logic [7:0]  cnt [3];
   logic        dir [3];
   logic        prdy, perr, err, en, mode;
   int          n_mismatch = 0;
   int          checked = 0;
   always #50 i_clk = ~i_clk;
   qd_top dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(strb), .o_prdata(prdata),
      .o_pready(prdy), .o_pslverr(perr), .i_x_phase_a(pa[0]), .i_x_phase_b(pb[0]),
      .i_y_phase_a(pa[1]), .i_y_phase_b(pb[1]), .i_z_phase_a(pa[2]), .i_z_phase_b(pb[2]));
   qd_enc_model enc [2:0] (.i_clk(i_clk), .i_req(req), .i_up(up), .o_a(pa), .o_b(pb));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   // Expected count after one step; mode one restarts at one on reversal
   function automatic logic [7:0] nxt(input logic [7:0] c, input logic d, u, m);
      if (m) return (u != d) ? 8'h01 : c + 8'h01;
      return u ? c + 8'h01 : c - 8'h01;
   endfunction : nxt
   task automatic conclude();
      if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
      int i;
      @(posedge i_clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= {14'h0000, idx, 2'h0};
      pwdata <= d;
      @(posedge i_clk);
      pen <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge i_clk);
         if (prdy === 1'b1) break;
      end
      if (i == 16) begin
         n_mismatch++;
         conclude();
      end
      rd = prdata;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic check_all();
      for (int k = 0; k < 3; k++) begin
         apb(1'b0, QD_IDX_X_DIRECTION + 16'(2 * k), 32'h0);
         chk(rd, {31'h0, dir[k]});
         apb(1'b0, QD_IDX_X_COUNT + 16'(2 * k), 32'h0);
         chk(rd, {24'h0, cnt[k]});
      end
   endtask : check_all
   // One encoder edge on axis k, then room for synchroniser and counter
   task automatic step(input int k, input logic u);
      @(posedge i_clk);
      req[k] <= 1'b1;
      up[k] <= u;
      @(posedge i_clk);
      req[k] <= 1'b0;
      repeat (5) @(posedge i_clk);
      if (en) begin
         cnt[k] = nxt(cnt[k], dir[k], u, mode);
         dir[k] = u;
      end
   endtask : step
   task automatic clear_model();
      for (int k = 0; k < 3; k++) begin
         cnt[k] = 8'h00;
         dir[k] = 1'b0;
      end
   endtask : clear_model
   initial begin
      en = 1'b0;
      mode = 1'b0;
      clear_model();
      repeat (10) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      // Reset state, read-only refusal and an unmapped index
      check_all();
      apb(1'b0, QD_IDX_DECODER_CONTROL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, QD_IDX_Y_COUNT, 32'h0000_00ff);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 16'h2567, 32'h0);
      chk({err, rd[30:0]}, 32'h8000_0000);
      step(1, 1'b1);
      check_all();
      // Both counting modes, each started by init, with random walks
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, QD_IDX_DECODER_CONTROL, {29'h0, 2'h3, m[0]});
         apb(1'b0, QD_IDX_DECODER_CONTROL, 32'h0);
         chk(rd, {29'h0, 2'h2, m[0]});
         en = 1'b1;
         mode = m[0];
         clear_model();
         step(0, 1'b0);
         check_all();
         for (int j = 0; j < 60; j++) begin
            seed = xs(seed);
            step(int'(seed[9:2] % 8'h03), seed[12]);
            if (j % 15 == 14) check_all();
         end
      end
      // Disabled decoder holds its counts; init needs the low strobe
      apb(1'b1, QD_IDX_DECODER_CONTROL, 32'h0);
      en = 1'b0;
      step(2, 1'b1);
      check_all();
      strb <= 4'he;
      apb(1'b1, QD_IDX_DECODER_CONTROL, 32'h0000_0002);
      check_all();
      strb <= 4'hf;
      apb(1'b1, QD_IDX_DECODER_CONTROL, 32'h0000_0002);
      clear_model();
      check_all();
      conclude();
   end
endmodule : qd_top_tb
